// ### design/hsfm_ctrl.sv
// high-side fault mask, fault flags and sense mux control register bank
//
// Overview of operation
// [R01] mask bit 0 inhibits drivers 1-2 thermal
// [R02] mask bit 1 inhibits driver 1 overcurrent
// [R03] mask bit 2 inhibits driver 1 open load
// [R04] mask bit 4 inhibits driver 2 overcurrent
// [R05] mask bit 5 inhibits driver 2 open load
// [R06] mask bit 7 inhibits drivers 3-4 thermal
// [R07] mask bit 8 inhibits driver 3 overcurrent
// [R08] mask bit 9 inhibits driver 3 open load
// [R09] mask bit 11 inhibits driver 4 overcurrent
// [R10] mask bit 12 inhibits driver 4 open load
// [R11] reset clears masks; unused bits read zero
// [R12] codes 0-5 pick ground, supplies, bias
// [R13] codes 6-11 pick divided high-voltage inputs
// [R14] codes 12-16 temperatures, io supply; rest reserved
// [R15] bit 8 picks divider 10.5 or 20
// [R16] bit 9 enables output, normal mode only
// [R17] events set flags; write one clears
// [R18] request when unmasked flag is set
module hsfm_ctrl
    import hsfm_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [3:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic [15:0] FAULT_EVENT,
    input wire logic NORMAL_MODE,
    output logic FAULT_IRQ,
    output logic [15:0] FAULT_PENDING,
    output logic [16:0] SENSE_SELECT,
    output logic SENSE_HV_PATH,
    output logic SENSE_DIV_HIGH,
    output logic SENSE_OUT_EN,
    output logic SENSE_PULLDOWN_EN,
    output logic SENSE_RESERVED
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [15:0] fault_mask;
    logic [15:0] sense_channel_select_ctrl;
    logic [15:0] next_fault_mask;
    logic [15:0] next_sense_channel_select_ctrl;
    logic [15:0] next_rdata;
    logic [16:0] next_select;
    logic next_hv_path;
    logic next_div_high;
    logic next_out_en;
    logic next_reserved;

    hsfm_fault_if fif ();

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire hit_mask = (REG_ADDR == HSFM_IDX_FAULT_MASK);
    wire hit_sense_channel_select = (REG_ADDR == HSFM_IDX_SENSE_CHANNEL_SELECT_CTRL);
    wire hit_flag = (REG_ADDR == HSFM_IDX_FAULT_FLAG);
    wire wr_mask = REG_WR & hit_mask;
    wire wr_sense_channel_select = REG_WR & hit_sense_channel_select;
    wire wr_flag = REG_WR & hit_flag;

    // ------------------------------------------------------------------
    // fault mask register
    // ------------------------------------------------------------------
    // named views of each inhibit bit
    wire drv12_thermal_mask = fault_mask[HSFM_BIT_DRV12_THERMAL];
    wire drv1_overcurrent_mask = fault_mask[HSFM_BIT_DRV1_OVERCURRENT];
    wire drv1_openload_mask = fault_mask[HSFM_BIT_DRV1_OPENLOAD];
    wire drv2_overcurrent_mask = fault_mask[HSFM_BIT_DRV2_OVERCURRENT];
    wire drv2_openload_mask = fault_mask[HSFM_BIT_DRV2_OPENLOAD];
    wire drv34_thermal_mask = fault_mask[HSFM_BIT_DRV34_THERMAL];
    wire drv3_overcurrent_mask = fault_mask[HSFM_BIT_DRV3_OVERCURRENT];
    wire drv3_openload_mask = fault_mask[HSFM_BIT_DRV3_OPENLOAD];
    wire drv4_overcurrent_mask = fault_mask[HSFM_BIT_DRV4_OVERCURRENT];
    wire drv4_openload_mask = fault_mask[HSFM_BIT_DRV4_OPENLOAD];

    // unused positions never store a one
    assign next_fault_mask = wr_mask ? (REG_WDATA & HSFM_FAULT_VALID) : fault_mask; // [R11]

    // mask reaches the flag bank bit by bit
    assign fif.mask[HSFM_BIT_DRV12_THERMAL] = drv12_thermal_mask; // [R01]
    assign fif.mask[HSFM_BIT_DRV1_OVERCURRENT] = drv1_overcurrent_mask; // [R02]
    assign fif.mask[HSFM_BIT_DRV1_OPENLOAD] = drv1_openload_mask; // [R03]
    assign fif.mask[3] = 1'b0;
    assign fif.mask[HSFM_BIT_DRV2_OVERCURRENT] = drv2_overcurrent_mask; // [R04]
    assign fif.mask[HSFM_BIT_DRV2_OPENLOAD] = drv2_openload_mask; // [R05]
    assign fif.mask[6] = 1'b0;
    assign fif.mask[HSFM_BIT_DRV34_THERMAL] = drv34_thermal_mask; // [R06]
    assign fif.mask[HSFM_BIT_DRV3_OVERCURRENT] = drv3_overcurrent_mask; // [R07]
    assign fif.mask[HSFM_BIT_DRV3_OPENLOAD] = drv3_openload_mask; // [R08]
    assign fif.mask[10] = 1'b0;
    assign fif.mask[HSFM_BIT_DRV4_OVERCURRENT] = drv4_overcurrent_mask; // [R09]
    assign fif.mask[HSFM_BIT_DRV4_OPENLOAD] = drv4_openload_mask; // [R10]
    assign fif.mask[15:13] = 3'h0;

    // ------------------------------------------------------------------
    // fault flags: write one to clear
    // ------------------------------------------------------------------
    assign fif.clear = wr_flag ? (REG_WDATA & HSFM_FAULT_VALID) : 16'h0000; // [R17]

    hsfm_flag_bank u_flags (
        .clk (CORE_CLK),
        .rst (RST),
        .fault_event (FAULT_EVENT),
        .fif (fif)
    );

    // ------------------------------------------------------------------
    // sense mux control register
    // ------------------------------------------------------------------
    assign next_sense_channel_select_ctrl = wr_sense_channel_select ? (REG_WDATA & HSFM_SENSE_CHANNEL_SELECT_VALID) : sense_channel_select_ctrl;

    wire [4:0] sense_channel_select = sense_channel_select_ctrl[HSFM_CH_LSB +: HSFM_CH_W];
    wire sense_divider_select = sense_channel_select_ctrl[HSFM_BIT_DIV_SEL];
    wire sense_mux_enable = sense_channel_select_ctrl[HSFM_BIT_MUX_EN];

    // ------------------------------------------------------------------
    // channel decode, one select line per source
    // ------------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < HSFM_NUM_CH; c++) begin : g_ch
            // codes 0..16 map straight to select lines
            assign next_select[c] = (sense_channel_select == 5'(c)); // [R12] [R13] [R14]
        end
    endgenerate

    // high-voltage channels through the divider
    wire ch_hv = (sense_channel_select >= HSFM_CH_BATTERY_SUPPLY)
               && (sense_channel_select <= HSFM_CH_HIGH_VOLTAGE_IO_TWO); // [R13]
    // codes above the io supply select nothing
    wire ch_reserved = (sense_channel_select > HSFM_CH_LAST_VALID); // [R14]

    assign next_hv_path = ch_hv; // [R13]
    // divider ratio only matters on the high-voltage path
    assign next_div_high = ch_hv & sense_divider_select; // [R15]
    assign next_reserved = ch_reserved; // [R14]
    // drive only when enabled, in normal mode, on a real channel
    assign next_out_en = sense_mux_enable & NORMAL_MODE & ~ch_reserved; // [R16]

    // ------------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 16'h0000;
        if (hit_mask) begin
            next_rdata = fault_mask & HSFM_FAULT_VALID; // [R11]
        end else if (hit_sense_channel_select) begin
            next_rdata = sense_channel_select_ctrl & HSFM_SENSE_CHANNEL_SELECT_VALID;
        end else if (hit_flag) begin
            next_rdata = fif.flags;
        end else begin
            next_rdata = 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // control storage, cleared at reset
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            fault_mask <= HSFM_FAULT_MASK_RESET; // [R11]
            sense_channel_select_ctrl <= HSFM_SENSE_CHANNEL_SELECT_RESET;
        end else begin
            fault_mask <= next_fault_mask;
            sense_channel_select_ctrl <= next_sense_channel_select_ctrl;
        end
    end

    // read port, answers one cycle after the request
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            REG_RDATA <= 16'h0000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= next_rdata;
            end
        end
    end

    // sense mux steering outputs
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            SENSE_SELECT <= 17'h00000;
            SENSE_HV_PATH <= 1'b0;
            SENSE_DIV_HIGH <= 1'b0;
            SENSE_OUT_EN <= 1'b0;
            SENSE_PULLDOWN_EN <= 1'b1;
            SENSE_RESERVED <= 1'b0;
        end else begin
            SENSE_SELECT <= next_select;
            SENSE_HV_PATH <= next_hv_path;
            SENSE_DIV_HIGH <= next_div_high; // [R15]
            SENSE_OUT_EN <= next_out_en; // [R16]
            SENSE_PULLDOWN_EN <= ~next_out_en; // [R16]
            SENSE_RESERVED <= next_reserved;
        end
    end

    // ------------------------------------------------------------------
    // fault request outputs
    // ------------------------------------------------------------------
    // pending view: flags that are not inhibited
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            FAULT_PENDING <= 16'h0000;
        end else begin
            FAULT_PENDING <= fif.flags & ~fif.mask & HSFM_FAULT_VALID; // [R18]
        end
    end

    assign FAULT_IRQ = fif.irq; // [R18]

endmodule : hsfm_ctrl

// ### design/hsfm_pkg.sv
// constants for the high-side fault mask and sense mux control bank
package hsfm_pkg;

    // ------------------------------------------------------------------
    // register indices on the register access port
    // ------------------------------------------------------------------
    localparam logic [3:0] HSFM_IDX_FAULT_MASK = 4'h0;
    localparam logic [3:0] HSFM_IDX_SENSE_CHANNEL_SELECT_CTRL = 4'h1;
    localparam logic [3:0] HSFM_IDX_FAULT_FLAG = 4'h2;

    // ------------------------------------------------------------------
    // fault mask and flag layout, shared bit positions
    // ------------------------------------------------------------------
    localparam int HSFM_DATA_W = 16;
    localparam int HSFM_BIT_DRV12_THERMAL = 0;
    localparam int HSFM_BIT_DRV1_OVERCURRENT = 1;
    localparam int HSFM_BIT_DRV1_OPENLOAD = 2;
    localparam int HSFM_BIT_DRV2_OVERCURRENT = 4;
    localparam int HSFM_BIT_DRV2_OPENLOAD = 5;
    localparam int HSFM_BIT_DRV34_THERMAL = 7;
    localparam int HSFM_BIT_DRV3_OVERCURRENT = 8;
    localparam int HSFM_BIT_DRV3_OPENLOAD = 9;
    localparam int HSFM_BIT_DRV4_OVERCURRENT = 11;
    localparam int HSFM_BIT_DRV4_OPENLOAD = 12;
    localparam logic [15:0] HSFM_FAULT_VALID = 16'h1bb7;
    localparam logic [15:0] HSFM_FAULT_MASK_RESET = 16'h0000;
    localparam logic [15:0] HSFM_FAULT_FLAG_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // sense mux control layout
    // ------------------------------------------------------------------
    localparam int HSFM_CH_LSB = 0;
    localparam int HSFM_CH_W = 5;
    localparam int HSFM_BIT_DIV_SEL = 8;
    localparam int HSFM_BIT_MUX_EN = 9;
    localparam logic [15:0] HSFM_SENSE_CHANNEL_SELECT_VALID = 16'h031f;
    localparam logic [15:0] HSFM_SENSE_CHANNEL_SELECT_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // sense channel codes
    // ------------------------------------------------------------------
    localparam int HSFM_NUM_CH = 17;
    localparam logic [4:0] HSFM_CH_ANALOG_GROUND = 5'h00;
    localparam logic [4:0] HSFM_CH_INTERNAL_DIGITAL_SUPPLY = 5'h01;
    localparam logic [4:0] HSFM_CH_REGULATOR_OUTPUT_ONE = 5'h02;
    localparam logic [4:0] HSFM_CH_REGULATOR_OUTPUT_TWO = 5'h03;
    localparam logic [4:0] HSFM_CH_REGULATOR_OUTPUT_THREE = 5'h04;
    localparam logic [4:0] HSFM_CH_INTERNAL_BIAS_VOLTAGE = 5'h05;
    localparam logic [4:0] HSFM_CH_BATTERY_SUPPLY = 5'h06;
    localparam logic [4:0] HSFM_CH_DRIVER_SUPPLY = 5'h07;
    localparam logic [4:0] HSFM_CH_WAKE_INPUT_ONE = 5'h08;
    localparam logic [4:0] HSFM_CH_WAKE_INPUT_TWO = 5'h09;
    localparam logic [4:0] HSFM_CH_HIGH_VOLTAGE_IO_ONE = 5'h0a;
    localparam logic [4:0] HSFM_CH_HIGH_VOLTAGE_IO_TWO = 5'h0b;
    localparam logic [4:0] HSFM_CH_DIE_TEMPERATURE = 5'h0c;
    localparam logic [4:0] HSFM_CH_REG1_TEMPERATURE = 5'h0d;
    localparam logic [4:0] HSFM_CH_REG2_TEMPERATURE = 5'h0e;
    localparam logic [4:0] HSFM_CH_REG3_TEMPERATURE = 5'h0f;
    localparam logic [4:0] HSFM_CH_IO_SUPPLY = 5'h10;
    localparam logic [4:0] HSFM_CH_LAST_VALID = 5'h10;

endpackage : hsfm_pkg

// ### design/hsfm_fault_if.sv
// carrier between the register bank and the fault flag bank
interface hsfm_fault_if;
    logic [15:0] mask;
    logic [15:0] clear;
    logic [15:0] flags;
    logic irq;

    // register side drives mask and clear strobes
    modport regs (
        output mask,
        output clear,
        input flags,
        input irq
    );

    // flag side holds the sticky flags and the request
    modport flagbank (
        input mask,
        input clear,
        output flags,
        output irq
    );
endinterface : hsfm_fault_if

// ### design/hsfm_flag_bank.sv
// sticky fault flags with pin synchronisers and masked request
module hsfm_flag_bank
    import hsfm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] fault_event,
    hsfm_fault_if.flagbank fif
);

    // ------------------------------------------------------------------
    // per-bit synchroniser, qualifier and sticky flag
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < HSFM_DATA_W; i++) begin : g_bit
            if (HSFM_FAULT_VALID[i]) begin : g_used
                logic sync1;
                logic sync2;
                logic sync3;
                logic stable;
                logic rise;
                logic flag;
                logic next_flag;
                // a rise counts once second and third stages agree high
                assign rise = sync2 & sync3 & ~stable;
                // set wins over a write-one clear in the same cycle
                assign next_flag = rise | (flag & ~fif.clear[i]); // [R17]
                always_ff @(posedge clk) begin
                    if (rst) begin
                        sync1 <= 1'b0;
                        sync2 <= 1'b0;
                        sync3 <= 1'b0;
                        stable <= 1'b0;
                        flag <= 1'b0;
                    end else begin
                        sync1 <= fault_event[i];
                        sync2 <= sync1;
                        sync3 <= sync2;
                        if (sync2 == sync3) begin
                            stable <= sync3;
                        end
                        flag <= next_flag; // [R17]
                    end
                end
                assign fif.flags[i] = flag;
            end else begin : g_unused
                assign fif.flags[i] = 1'b0;
            end
        end
    endgenerate

    // request whenever any flag is set with its mask bit clear
    assign fif.irq = |(fif.flags & ~fif.mask & HSFM_FAULT_VALID); // [R18]

endmodule : hsfm_flag_bank

// ### tb/hsfm_ctrl_props.sv
// concurrent checks on the ports of the fault mask and sense mux bank
module hsfm_ctrl_props
    import hsfm_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [3:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic NORMAL_MODE,
    input wire logic FAULT_IRQ,
    input wire logic [15:0] FAULT_PENDING,
    input wire logic [16:0] SENSE_SELECT,
    input wire logic SENSE_HV_PATH,
    input wire logic SENSE_DIV_HIGH,
    input wire logic SENSE_OUT_EN,
    input wire logic SENSE_PULLDOWN_EN,
    input wire logic SENSE_RESERVED
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // port relations, all in the core clock domain
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    AST_RD_ANSWER: assert property (REG_RD |=> REG_RVALID)
        else $error("read strobe not answered one cycle later");
    AST_RVALID_CAUSE: assert property (REG_RVALID |-> $past(REG_RD))
        else $error("read answer without a read strobe");
    AST_MASK_UNUSED: assert property (REG_RVALID
        && $past(REG_ADDR) == HSFM_IDX_FAULT_MASK |-> (REG_RDATA & ~HSFM_FAULT_VALID) == 16'h0000)
        else $error("unused mask bit read back as one");
    AST_MUX_UNUSED: assert property (REG_RVALID
        && $past(REG_ADDR) == HSFM_IDX_SENSE_CHANNEL_SELECT_CTRL |-> (REG_RDATA & ~HSFM_SENSE_CHANNEL_SELECT_VALID) == 16'h0000)
        else $error("unused mux control bit read back as one");
    AST_IRQ_PENDING: assert property ((|FAULT_PENDING) == $past(FAULT_IRQ))
        else $error("pending vector disagrees with request");
    AST_PENDING_LAYOUT: assert property ((FAULT_PENDING & ~HSFM_FAULT_VALID) == 16'h0000)
        else $error("pending bit at an unused position");
    AST_PULLDOWN_INV: assert property (SENSE_PULLDOWN_EN != SENSE_OUT_EN)
        else $error("pull-down and output drive not complementary");
    AST_OUT_NORMAL: assert property (SENSE_OUT_EN |-> $past(NORMAL_MODE))
        else $error("mux output driven outside normal mode");
    AST_DIV_ONLY_HV: assert property (SENSE_DIV_HIGH |-> SENSE_HV_PATH)
        else $error("high divider outside high-voltage channels");
    AST_HV_CHANNELS: assert property (SENSE_HV_PATH == (|SENSE_SELECT[11:6]))
        else $error("divided path flag disagrees with channel");
    AST_SELECT_ONEHOT: assert property ($onehot0(SENSE_SELECT)
        && !(SENSE_RESERVED && (|SENSE_SELECT)))
        else $error("channel select not one-hot or reserved code routed");
    // main scenarios
    COV_IRQ: cover property ($rose(FAULT_IRQ));
    COV_OUT: cover property ($rose(SENSE_OUT_EN));
    COV_RESERVED: cover property (SENSE_RESERVED);
endmodule : hsfm_ctrl_props

// ### tb/hsfm_host.sv
// host model issuing register writes and reads on the bank's register port
module hsfm_host
    import hsfm_pkg::*;
(
    input wire logic clk,
    output logic [3:0] addr,
    output logic wr,
    output logic rd,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow = 1'b0; // extra idle cycle before each request
    initial begin
        addr = 4'h0;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 16'h0000;
    end
    // one write strobe; released address and data show their inverse
    task automatic put(input logic [3:0] a, input logic [15:0] d);
        if (slow) @(negedge clk);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask : put
    // one read strobe; answer taken in the cycle after
    task automatic get(input logic [3:0] a, output logic [15:0] d, output logic v);
        if (slow) @(negedge clk);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        d = rdata;
        v = rvalid;
    endtask : get
endmodule : hsfm_host

// ### tb/hsfm_ctrl_tb.sv
// self-checking bench for the fault mask and sense mux register bank
module hsfm_ctrl_tb
    import hsfm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [15:0] w; logic nm; logic [16:0] sel; logic [4:0] out;} hsfm_row_s;
    logic core_clk;
    logic rst = 1'b1;
    logic normal_mode = 1'b1;
    logic [15:0] fault_event = 16'h0000;
    logic [3:0] reg_addr;
    logic reg_wr, reg_rd, reg_rvalid, fault_irq;
    logic [15:0] reg_wdata, reg_rdata, fault_pending, rd_val, one;
    logic [16:0] sense_select;
    logic sense_hv_path, sense_div_high, sense_out_en, sense_pulldown_en, sense_reserved;
    logic rd_ok;
    int err_total = 0;
    int total_checks = 0;
    int bits [10] = '{0, 1, 2, 4, 5, 7, 8, 9, 11, 12};
    wire [4:0] sense_flags = {sense_hv_path, sense_div_high, sense_out_en,
        sense_pulldown_en, sense_reserved};
    // mux control word and mode beside the outputs they should give
    hsfm_row_s rows [8] = '{
        '{16'h0000, 1'b1, 17'h00001, 5'b00010}, '{16'h0206, 1'b1, 17'h00040, 5'b10100},
        '{16'h0306, 1'b1, 17'h00040, 5'b11100}, '{16'h030b, 1'b0, 17'h00800, 5'b11010},
        '{16'h0305, 1'b1, 17'h00020, 5'b00100}, '{16'h0210, 1'b1, 17'h10000, 5'b00100},
        '{16'h0211, 1'b1, 17'h00000, 5'b00011}, '{16'hfc0c, 1'b1, 17'h01000, 5'b00010}};

    hsfm_ctrl u_hsfm_ctrl (.CORE_CLK(core_clk), .RST(rst), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .FAULT_EVENT(fault_event), .NORMAL_MODE(normal_mode),
        .FAULT_IRQ(fault_irq), .FAULT_PENDING(fault_pending), .SENSE_SELECT(sense_select),
        .SENSE_HV_PATH(sense_hv_path), .SENSE_DIV_HIGH(sense_div_high),
        .SENSE_OUT_EN(sense_out_en), .SENSE_PULLDOWN_EN(sense_pulldown_en),
        .SENSE_RESERVED(sense_reserved));
    hsfm_host u_hsfm_host (.clk(core_clk), .addr(reg_addr), .wr(reg_wr), .rd(reg_rd),
        .wdata(reg_wdata), .rdata(reg_rdata), .rvalid(reg_rvalid));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ----------------------------------------------------------------
    // compare and closing tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        u_hsfm_host.get(a, rd_val, rd_ok);
        chk({16'h0000, rd_ok}, 17'h00001);
        chk({1'b0, rd_val}, {1'b0, exp});
    endtask : rdchk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        rdchk(HSFM_IDX_FAULT_MASK, 16'h0000);
        rdchk(HSFM_IDX_SENSE_CHANNEL_SELECT_CTRL, 16'h0000);
        chk({12'h000, sense_flags}, 17'h00002);
        u_hsfm_host.slow = 1'b1;
        for (int i = 0; i < 8; i++) begin
            normal_mode = rows[i].nm;
            u_hsfm_host.put(HSFM_IDX_SENSE_CHANNEL_SELECT_CTRL, rows[i].w);
            repeat (2) @(negedge core_clk);
            chk(sense_select, rows[i].sel);
            chk({12'h000, sense_flags}, {12'h000, rows[i].out});
            rdchk(HSFM_IDX_SENSE_CHANNEL_SELECT_CTRL, rows[i].w & HSFM_SENSE_CHANNEL_SELECT_VALID);
        end
        u_hsfm_host.slow = 1'b0;
        normal_mode = 1'b1;
        for (int c = 0; c < 32; c++) begin
            u_hsfm_host.put(HSFM_IDX_SENSE_CHANNEL_SELECT_CTRL, 16'h0300 | 16'(c));
            repeat (2) @(negedge core_clk);
            chk(sense_select, (c <= 16) ? 17'h00001 << c : 17'h00000);
            chk({16'h0000, sense_hv_path}, {16'h0000, 1'((c >= 6) && (c <= 11))});
            chk({16'h0000, sense_out_en}, {16'h0000, 1'(c <= 16)});
        end
        u_hsfm_host.put(HSFM_IDX_FAULT_MASK, 16'hffff);
        rdchk(HSFM_IDX_FAULT_MASK, HSFM_FAULT_VALID);
        u_hsfm_host.put(4'h3, 16'hffff);
        rdchk(4'h3, 16'h0000);
        rst = 1'b1;
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        rdchk(HSFM_IDX_FAULT_MASK, 16'h0000);
        rdchk(HSFM_IDX_SENSE_CHANNEL_SELECT_CTRL, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            one = 16'h0001 << bits[i];
            u_hsfm_host.put(HSFM_IDX_FAULT_MASK, one);
            fault_event = one;
            repeat (6) @(negedge core_clk);
            chk(17'(fault_irq), 17'h00000);
            chk(17'(fault_pending), 17'h00000);
            rdchk(HSFM_IDX_FAULT_FLAG, one);
            u_hsfm_host.put(HSFM_IDX_FAULT_MASK, HSFM_FAULT_VALID & ~one);
            repeat (2) @(negedge core_clk);
            chk({16'h0000, fault_irq}, 17'h00001);
            chk({1'b0, fault_pending}, {1'b0, one});
            u_hsfm_host.put(HSFM_IDX_FAULT_FLAG, one);
            fault_event = 16'h0000;
            @(negedge core_clk);
            chk({16'h0000, fault_irq}, 17'h00000);
        end
        // event rise and write-one clear land on one edge: the set wins
        fault_event = 16'h0002;
        repeat (2) @(negedge core_clk);
        u_hsfm_host.put(HSFM_IDX_FAULT_FLAG, 16'h0002);
        rdchk(HSFM_IDX_FAULT_FLAG, 16'h0002);
        chk({16'h0000, fault_irq}, 17'h00000);
        u_hsfm_host.put(HSFM_IDX_FAULT_FLAG, 16'h0002);
        fault_event = 16'h0000;
        rdchk(HSFM_IDX_FAULT_FLAG, 16'h0000);
        report_and_stop();
    end
endmodule : hsfm_ctrl_tb

bind hsfm_ctrl hsfm_ctrl_props u_hsfm_ctrl_props (.CORE_CLK(CORE_CLK), .RST(RST),
    .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .NORMAL_MODE(NORMAL_MODE), .FAULT_IRQ(FAULT_IRQ), .FAULT_PENDING(FAULT_PENDING),
    .SENSE_SELECT(SENSE_SELECT), .SENSE_HV_PATH(SENSE_HV_PATH),
    .SENSE_DIV_HIGH(SENSE_DIV_HIGH), .SENSE_OUT_EN(SENSE_OUT_EN),
    .SENSE_PULLDOWN_EN(SENSE_PULLDOWN_EN), .SENSE_RESERVED(SENSE_RESERVED));
